// *** param_regs_pkg.sv ***
package param_regs_pkg;
  localparam logic [15:0] ADDR_CUSTOM_SW_LO = 16'hFFDA;
  localparam logic [15:0] ADDR_CUSTOM_SW_HI = 16'hFFDB;
  localparam logic [15:0] ADDR_WTX_LO = 16'hFFDE;
  localparam logic [15:0] ADDR_WTX_HI = 16'hFFDF;
  localparam logic [15:0] ADDR_BUF_START_LO = 16'hFFE4;
  localparam logic [15:0] ADDR_BUF_START_HI = 16'hFFE5;
  localparam logic [15:0] ADDR_FILE_OFS_LO = 16'hFFE6;
  localparam logic [15:0] ADDR_FILE_OFS_HI = 16'hFFE7;
  localparam logic [15:0] ADDR_BLOCK_LEN_LO = 16'hFFE8;
  localparam logic [15:0] ADDR_BLOCK_LEN_HI = 16'hFFE9;
  localparam logic [15:0] ADDR_HOST_RESP = 16'hFFEA;
  localparam int CUSTOM_SW_EN_BIT = 2;
  localparam logic [15:0] RST_CUSTOM_SW = 16'h0000;
  localparam logic [7:0] RST_WTX = 8'h01;
  localparam logic [15:0] RST_BUF_START = 16'h0000;
  localparam logic [15:0] RST_FILE_OFS = 16'h0000;
  localparam logic [15:0] RST_BLOCK_LEN = 16'h0000;
  localparam logic [7:0] RST_HOST_RESP = 8'h00;
  localparam logic [7:0] S_WTX_PCB = 8'hF2;
  localparam int FWT_US = 5;
  localparam int CLK_MHZ = 100;
  localparam int FWT_CYCLES = FWT_US * CLK_MHZ;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } host_req_t;

  typedef struct packed {
    logic start;
    logic is_update;
    logic [15:0] offset;
    logic [15:0] length;
    logic [15:0] buf_index;
  } cmd_info_t;

  typedef struct packed {
    logic valid;
    logic is_wtx;
    logic [7:0] byte1;
    logic [7:0] byte2;
  } resp_t;
endpackage

// *** fwt_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module fwt_timer #(
  parameter int CYCLES = 500
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic restart,
  input wire logic stop,
  output logic expired
);
  logic [15:0] cnt_r, cnt_nxt;
  logic run_r, run_nxt;
  logic exp_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    run_nxt = run_r;
    exp_nxt = 1'b0;
    if (restart) begin
      cnt_nxt = 16'(CYCLES - 1);
      run_nxt = 1'b1;
    end else if (stop) begin
      run_nxt = 1'b0;
    end else if (run_r) begin
      if (cnt_r == 16'h0000) begin
        run_nxt = 1'b0;
        exp_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r - 16'h0001;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 16'h0000;
      run_r <= 1'b0;
      expired <= 1'b0;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
      expired <= exp_nxt;
    end
  end
endmodule
`default_nettype wire

// *** param_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
// Contract
// [RULE1] File offset of each pass-through command is reported in a 16-bit register, high byte at the upper address, reset zero.
// [RULE2] After a Read Binary the host writes the buffer index where it placed the data into the buffer-start register.
// [RULE3] On Update Binary the device loads buffer-start with the index where it stored the packet.
// [RULE4] Each reader command is answered within the negotiated frame waiting time.
// [RULE5] When that time cannot be met, an S(WTX) request goes out instead of the response.
// [RULE6] After the reader's S(WTX) response the waiting time restarts for the pending command.
// [RULE7] The S(WTX) INF byte is the low byte of the wait-extension register, which resets to one.
// [RULE8] The host writes zeros to the reserved upper wait-extension byte, which resets to zero.
// [RULE9] Every Select, Read Binary or Update Binary response ends with a two-byte status word.
// [RULE10] By default the device chooses the status word from fixed internal values; here it comes from the default_sw input port.
// [RULE11] With custom status enabled the custom status register supplies the status word.
// [RULE12] SW1 comes from the upper custom status byte and SW2 from the lower, both reset zero.
// [RULE13] No boundary-scan test access is provided.
// [RULE14] The host enables custom status through bit 2 of the host response register.
// [RULE15] Block length of each command is reported in a 16-bit register, high byte upper.
// [RULE16] The host writes buffer-start and custom status before signalling service done.
module param_regs (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire param_regs_pkg::host_req_t host_req,
  output logic [7:0] host_rdata,
  output logic host_rvalid,
  input wire param_regs_pkg::cmd_info_t cmd_info,
  input wire logic resp_ready,
  input wire logic [15:0] default_sw,
  input wire logic wtx_ack,
  output param_regs_pkg::resp_t resp,
  output logic custom_status_enable,
  output logic [15:0] buffer_start
);
  import param_regs_pkg::*;

  // [RULE13] No test access port exists in this block.
  typedef enum {ST_IDLE, ST_WAIT, ST_WTX} st_t;
  st_t st_r, st_nxt;

  logic [15:0] file_ofs_r, file_ofs_nxt;
  logic [15:0] block_len_r, block_len_nxt;
  logic [15:0] buf_start_r, buf_start_nxt;
  logic [15:0] custom_sw_r, custom_sw_nxt;
  logic [7:0] wtx_lo_r, wtx_lo_nxt;
  logic [7:0] wtx_hi_r, wtx_hi_nxt;
  logic [7:0] host_resp_r, host_resp_nxt;
  logic [7:0] rdata_nxt;
  logic rvalid_nxt;
  resp_t resp_nxt;
  logic timer_restart;
  logic timer_stop;
  logic timer_expired;

  function automatic logic [15:0] put_byte(input logic [15:0] cur,
                                           input logic hi,
                                           input logic [7:0] b);
    put_byte = hi ? {b, cur[7:0]} : {cur[15:8], b};
  endfunction

  function automatic logic hit(input logic [15:0] a,
                               input logic [15:0] lo,
                               input logic [15:0] hi);
    hit = (a == lo) || (a == hi);
  endfunction

  fwt_timer #(.CYCLES(FWT_CYCLES)) u_fwt (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .restart(timer_restart),
    .stop(timer_stop),
    .expired(timer_expired)
  );

  // Register file: host writes, device-side updates from commands
  always_comb begin
    logic hi;
    hi = 1'b0;
    file_ofs_nxt = file_ofs_r;
    block_len_nxt = block_len_r;
    buf_start_nxt = buf_start_r;
    custom_sw_nxt = custom_sw_r;
    wtx_lo_nxt = wtx_lo_r;
    wtx_hi_nxt = wtx_hi_r;
    host_resp_nxt = host_resp_r;
    if (host_req.wr) begin
      hi = host_req.addr[0];
      if (hit(host_req.addr, ADDR_FILE_OFS_LO, ADDR_FILE_OFS_HI)) begin
        file_ofs_nxt = put_byte(file_ofs_r, hi, host_req.wdata);
      end
      if (hit(host_req.addr, ADDR_BLOCK_LEN_LO, ADDR_BLOCK_LEN_HI)) begin
        block_len_nxt = put_byte(block_len_r, hi, host_req.wdata);
      end
      if (hit(host_req.addr, ADDR_BUF_START_LO, ADDR_BUF_START_HI)) begin
        buf_start_nxt = put_byte(buf_start_r, hi, host_req.wdata); // RULE2
      end
      if (hit(host_req.addr, ADDR_CUSTOM_SW_LO, ADDR_CUSTOM_SW_HI)) begin
        custom_sw_nxt = put_byte(custom_sw_r, hi, host_req.wdata);
      end
      if (host_req.addr == ADDR_WTX_LO) begin
        wtx_lo_nxt = host_req.wdata;
      end
      if (host_req.addr == ADDR_WTX_HI) begin
        wtx_hi_nxt = host_req.wdata; // RULE8
      end
      if (host_req.addr == ADDR_HOST_RESP) begin
        host_resp_nxt = host_req.wdata; // RULE14
      end
    end
    // Command capture wins over a host write in the same cycle
    if (cmd_info.start) begin
      file_ofs_nxt = cmd_info.offset; // RULE1
      block_len_nxt = cmd_info.length; // RULE15
      if (cmd_info.is_update) begin
        buf_start_nxt = cmd_info.buf_index; // RULE3
      end
    end
  end

  // Host read port, one cycle latency, unmapped reads return zero
  always_comb begin
    rvalid_nxt = host_req.rd;
    rdata_nxt = 8'h00;
    if (host_req.rd) begin
      unique case (host_req.addr)
        ADDR_FILE_OFS_LO: rdata_nxt = file_ofs_r[7:0];
        ADDR_FILE_OFS_HI: rdata_nxt = file_ofs_r[15:8];
        ADDR_BLOCK_LEN_LO: rdata_nxt = block_len_r[7:0];
        ADDR_BLOCK_LEN_HI: rdata_nxt = block_len_r[15:8];
        ADDR_BUF_START_LO: rdata_nxt = buf_start_r[7:0];
        ADDR_BUF_START_HI: rdata_nxt = buf_start_r[15:8];
        ADDR_CUSTOM_SW_LO: rdata_nxt = custom_sw_r[7:0];
        ADDR_CUSTOM_SW_HI: rdata_nxt = custom_sw_r[15:8];
        ADDR_WTX_LO: rdata_nxt = wtx_lo_r;
        ADDR_WTX_HI: rdata_nxt = wtx_hi_r;
        ADDR_HOST_RESP: rdata_nxt = host_resp_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  // Response sequencing against the frame waiting time
  always_comb begin
    st_nxt = st_r;
    resp_nxt = '0;
    timer_restart = 1'b0;
    timer_stop = 1'b0;
    unique case (st_r)
      ST_IDLE: begin
        if (cmd_info.start) begin
          st_nxt = ST_WAIT;
          timer_restart = 1'b1; // RULE4
        end
      end
      ST_WAIT: begin
        if (resp_ready) begin
          resp_nxt.valid = 1'b1; // RULE9
          if (host_resp_r[CUSTOM_SW_EN_BIT]) begin
            resp_nxt.byte1 = custom_sw_r[15:8]; // RULE11 RULE12
            resp_nxt.byte2 = custom_sw_r[7:0]; // RULE12
          end else begin
            resp_nxt.byte1 = default_sw[15:8]; // RULE10
            resp_nxt.byte2 = default_sw[7:0];
          end
          timer_stop = 1'b1;
          st_nxt = ST_IDLE;
        end else if (timer_expired) begin
          resp_nxt.valid = 1'b1; // RULE5
          resp_nxt.is_wtx = 1'b1;
          resp_nxt.byte1 = S_WTX_PCB;
          resp_nxt.byte2 = wtx_lo_r; // RULE7
          st_nxt = ST_WTX;
        end
      end
      ST_WTX: begin
        if (wtx_ack) begin
          timer_restart = 1'b1; // RULE6
          st_nxt = ST_WAIT;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r <= ST_IDLE;
      file_ofs_r <= RST_FILE_OFS;
      block_len_r <= RST_BLOCK_LEN;
      buf_start_r <= RST_BUF_START;
      custom_sw_r <= RST_CUSTOM_SW;
      wtx_lo_r <= RST_WTX;
      wtx_hi_r <= 8'h00;
      host_resp_r <= RST_HOST_RESP;
      host_rdata <= 8'h00;
      host_rvalid <= 1'b0;
      resp <= '0;
      custom_status_enable <= 1'b0;
      buffer_start <= RST_BUF_START;
    end else if (ce) begin
      st_r <= st_nxt;
      file_ofs_r <= file_ofs_nxt;
      block_len_r <= block_len_nxt;
      buf_start_r <= buf_start_nxt;
      custom_sw_r <= custom_sw_nxt;
      wtx_lo_r <= wtx_lo_nxt;
      wtx_hi_r <= wtx_hi_nxt;
      host_resp_r <= host_resp_nxt;
      host_rdata <= rdata_nxt;
      host_rvalid <= rvalid_nxt;
      resp <= resp_nxt;
      custom_status_enable <= host_resp_nxt[CUSTOM_SW_EN_BIT];
      buffer_start <= buf_start_nxt;
    end
  end
endmodule
`default_nettype wire

// *** param_regs_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module param_regs_assertions (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire param_regs_pkg::host_req_t host_req,
  input wire logic host_rvalid,
  input wire param_regs_pkg::cmd_info_t cmd_info,
  input wire logic [15:0] default_sw,
  input wire param_regs_pkg::resp_t resp,
  input wire logic custom_status_enable,
  input wire logic [15:0] buffer_start
);
  import param_regs_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  rd_answer_a: assert property (ce && host_req.rd |=> host_rvalid)
    else $error("read not answered");
  rvalid_cause_a: assert property (host_rvalid |-> $past(host_req.rd))
    else $error("read data without read");
  resp_pulse_a: assert property (resp.valid && ce |=> !resp.valid)
    else $error("response longer than one cycle");
  wtx_header_a: assert property (resp.valid && resp.is_wtx |->
    resp.byte1 == S_WTX_PCB) else $error("bad extension header");
  default_word_a: assert property (resp.valid && !resp.is_wtx &&
    !$past(custom_status_enable) |->
    {resp.byte1, resp.byte2} == $past(default_sw))
    else $error("default status word wrong");
  enable_bit_a: assert property (ce && host_req.wr &&
    host_req.addr == ADDR_HOST_RESP |=> custom_status_enable ==
    $past(host_req.wdata[CUSTOM_SW_EN_BIT])) else $error("enable bit wrong");
  buf_write_a: assert property (ce && host_req.wr && !cmd_info.start &&
    host_req.addr == ADDR_BUF_START_HI |=> buffer_start[15:8] ==
    $past(host_req.wdata)) else $error("buffer start write lost");
  freeze_a: assert property (!ce |=> $stable(buffer_start) &&
    $stable(custom_status_enable)) else $error("state moved while frozen");
endmodule
bind param_regs param_regs_assertions param_regs_assertions_inst (
  .ref_clk(ref_clk), .rst(rst), .ce(ce), .host_req(host_req),
  .host_rvalid(host_rvalid), .cmd_info(cmd_info), .default_sw(default_sw),
  .resp(resp), .custom_status_enable(custom_status_enable),
  .buffer_start(buffer_start));
`default_nettype wire

// *** reader_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module reader_model #(
  parameter int ACK_DELAY = 4
) (
  input wire logic ref_clk,
  input wire param_regs_pkg::resp_t resp,
  output logic wtx_ack
);
  import param_regs_pkg::*;
  // Answers every extension request after a delay, like a slow reader
  initial begin
    wtx_ack = 1'b0;
    forever begin
      @(negedge ref_clk);
      if (resp.valid && resp.is_wtx) begin
        repeat (ACK_DELAY) @(negedge ref_clk);
        wtx_ack = 1'b1;
        @(negedge ref_clk);
        wtx_ack = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// *** param_regs_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module param_regs_tb_top;
  import param_regs_pkg::*;
  logic ref_clk, rst, ce, resp_ready, host_rvalid, wtx_ack, cse;
  logic [15:0] default_sw, buffer_start, v, o, l, b;
  logic [15:0] wv [4];
  logic [7:0] host_rdata;
  host_req_t host_req;
  cmd_info_t cmd_info;
  resp_t resp;
  int fail_count, checks_done, n;
  localparam logic [15:0] RA [6] = '{ADDR_CUSTOM_SW_LO, ADDR_WTX_LO,
    ADDR_BUF_START_LO, ADDR_FILE_OFS_LO, ADDR_BLOCK_LEN_LO, 16'hFFE0};
  localparam logic [15:0] RV [6] = '{RST_CUSTOM_SW, {8'h00, RST_WTX},
    RST_BUF_START, RST_FILE_OFS, RST_BLOCK_LEN, 16'h0000};
  param_regs param_regs_inst (.ref_clk(ref_clk), .rst(rst), .ce(ce),
    .host_req(host_req), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
    .cmd_info(cmd_info), .resp_ready(resp_ready), .default_sw(default_sw),
    .wtx_ack(wtx_ack), .resp(resp), .custom_status_enable(cse),
    .buffer_start(buffer_start));
  reader_model reader_model_inst (.ref_clk(ref_clk), .resp(resp),
    .wtx_ack(wtx_ack));
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmp_resp(input resp_t g, input resp_t e);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  function automatic resp_t exp_sw(logic en, logic [15:0] c, logic [15:0] d);
    return '{1'b1, 1'b0, en ? c[15:8] : d[15:8], en ? c[7:0] : d[7:0]};
  endfunction
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    host_req = '{w, !w, a, d};
    @(negedge ref_clk);
    host_req = '0;
  endtask
  task automatic wr16(input logic [15:0] a, input logic [15:0] d);
    acc(1'b1, a, d[7:0]);
    acc(1'b1, a + 16'h0001, d[15:8]);
  endtask
  task automatic rd16(input logic [15:0] a);
    acc(1'b0, a, 8'h00);
    v[7:0] = host_rdata;
    acc(1'b0, a + 16'h0001, 8'h00);
    v[15:8] = host_rdata;
  endtask
  task automatic cmd(input logic u);
    o = 16'($urandom);
    l = 16'($urandom);
    b = 16'($urandom);
    @(negedge ref_clk);
    cmd_info = '{1'b1, u, o, l, b};
    @(negedge ref_clk);
    cmd_info.start = 1'b0;
  endtask
  task automatic ready_wait(input logic r);
    @(negedge ref_clk);
    resp_ready = r;
    @(negedge ref_clk);
    resp_ready = 1'b0;
    n = 0;
    while (!resp.valid && n < 900) begin
      @(negedge ref_clk);
      n++;
    end
    // A response that never comes counts as a mismatch
    if (n >= 900) cmp(16'(n), 16'(FWT_CYCLES));
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    #200000;
    fail_count++;
    results();
  end
  initial begin
    host_req = '0;
    cmd_info = '0;
    ce = 1'b1;
    resp_ready = 1'b0;
    rst = 1'b1;
    v = 16'($urandom(32'h832CA804));
    default_sw = 16'($urandom);
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk) rst = 1'b0;
    for (int k = 0; k < 6; k++) begin
      rd16(RA[k]);
      cmp(v, RV[k]);
    end
    for (int k = 0; k < 5; k++) begin
      if (k < 4) wv[k] = 16'($urandom);
      if (k == 1) wv[1][15:8] = 8'h00;
      wr16(RA[k], k == 4 ? 16'h5AA5 : wv[k]);
      rd16(RA[k == 4 ? 5 : k]);
      cmp(v, k == 4 ? 16'h0000 : wv[k]);
    end
    cmd(1'b1);
    cmp(buffer_start, b);
    rd16(ADDR_FILE_OFS_LO);
    cmp(v, o);
    rd16(ADDR_BLOCK_LEN_LO);
    cmp(v, l);
    ready_wait(1'b1);
    cmp_resp(resp, exp_sw(1'b0, wv[0], default_sw));
    acc(1'b1, ADDR_HOST_RESP, 8'h04);
    v = buffer_start;
    cmd(1'b0);
    cmp(buffer_start, v);
    ready_wait(1'b1);
    cmp_resp(resp, exp_sw(1'b1, wv[0], default_sw));
    wr16(ADDR_BUF_START_LO, ~b);
    cmp(buffer_start, ~b);
    @(negedge ref_clk) ce = 1'b0;
    acc(1'b1, ADDR_BUF_START_LO, b[7:0]);
    ce = 1'b1;
    cmp(buffer_start, ~b);
    cmd(1'b1);
    ready_wait(1'b0);
    cmp(16'(n > FWT_CYCLES - 6 && n < FWT_CYCLES + 6), 16'h0001);
    cmp_resp(resp, '{1'b1, 1'b1, S_WTX_PCB, wv[1][7:0]});
    repeat (400) @(negedge ref_clk);
    ready_wait(1'b1);
    cmp_resp(resp, exp_sw(1'b1, wv[0], default_sw));
    results();
  end
endmodule
`default_nettype wire
